// ### hdl/mmu_fault_map.svh
`ifndef MMU_FAULT_MAP_SVH
`define MMU_FAULT_MAP_SVH

// Register offsets (byte addresses on the plain register port)
`define REG_MAIN_CONTROL 5'h00
`define REG_DOMAIN_TABLE 5'h04
`define REG_DATA_FAULT_STATUS 5'h08
`define REG_INSTR_FAULT_STATUS 5'h0C
`define REG_FAULT_ADDRESS 5'h10

// Control register field positions
`define CTRL_MMU_EN_BIT 0
`define CTRL_ALIGN_EN_BIT 1
`define CTRL_SYS_PROT_BIT 8
`define CTRL_ROM_PROT_BIT 9

// Reset values
`define CTRL_RESET 32'h0000_0000
`define DOMAIN_TABLE_RESET 32'h0000_0000
`define FAULT_STATUS_RESET 8'h00
`define FAULT_ADDRESS_RESET 32'h0000_0000
`define DOMAIN_INVALID 4'h0

// Fault status codes
`define FS_ALIGN_BASE 4'h1
`define FS_WALK_L1 4'hC
`define FS_WALK_L2 4'hE
`define FS_TRANS_SECTION 4'h5
`define FS_TRANS_PAGE 4'h7
`define FS_DOMAIN_SECTION 4'h9
`define FS_DOMAIN_PAGE 4'hB
`define FS_PERM_SECTION 4'hD
`define FS_PERM_PAGE 4'hF
`define FS_EXT_SECTION 4'h8
`define FS_EXT_PAGE 4'hA

// Descriptor fields
`define DESC_TYPE_LSB 0
`define L1_DOMAIN_LSB 5
`define SECTION_AP_LSB 10
`define L2_AP_LSB 4
`define REGION_LSB 10

`endif

// ### hdl/mmu_fault_pkg.sv
package mmu_fault_pkg;
    // Access width from the load/store unit
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_HALF = 2'b01,
        SIZE_WORD = 2'b10
    } access_size_t;

    // Descriptor type field, low two bits
    typedef enum logic [1:0] {
        DESC_INVALID = 2'b00,
        DESC_TYPE_01 = 2'b01,
        DESC_TYPE_10 = 2'b10,
        DESC_TYPE_11 = 2'b11
    } desc_type_t;

    // Multi-word transfer tracking
    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_BUSY = 2'b01
    } xfer_state_t;
endpackage

// ### hdl/mmu_fault_check.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "mmu_fault_map.svh"

// Notes on behaviour
// - Alignment, translation, domain or permission faults abort the access.
// - External aborts only for walks, noncached reads, nonbuffered writes, swaps.
// - Alignment check follows its enable alone, translation on or off.
// - Translation, domain, permission faults need translation enabled.
// - A violating access never reaches the bus.
// - Data abort records code, domain and fault address.
// - Prefetch abort records instruction status; fault address unchanged.
// - Only the highest-priority simultaneous fault is recorded.
// - Alignment codes 0001 or 0011, domain invalid.
// - Walk abort codes 1100 first level, 1110 second level with domain.
// - Domain may be invalid before a descriptor domain is fetched.
// - Masked faults dropped; a retry after the fix reports them.
// - Checked multi-word faults record the first aborted word.
// - External multi-word aborts: last address before 1KB boundary, else final.
// - Domain table: sixteen two-bit fields in 32 bits.
// - Domain codes 00 and 10 always fault.
// - Client 01 checks permissions; manager 11 skips them.
// - Permission 00 follows system and ROM bits.
// - Misaligned words, halfwords fault; bytes and fetches never.
// - Alignment fault aborts without other checks.
// - Instruction status also written by prefetch maintenance.
// - First-level domain field selects a domain table field.
// - Descriptor type 00 raises a translation fault.
// - Small page permission chosen by accessed 1 KB quarter.
module mmu_fault_check (
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [4:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    // Access from the core
    input wire logic acc_valid_i,
    input wire logic acc_data_i,
    input wire logic acc_write_i,
    input wire logic acc_priv_i,
    input wire mmu_fault_pkg::access_size_t acc_size_i,
    input wire logic [31:0] modified_virtual_address_i,
    input wire logic acc_first_i,
    input wire logic acc_last_i,
    input wire logic acc_noncached_i,
    input wire logic acc_nonbuffered_i,
    input wire logic swap_lock_sequence_i,
    // Descriptors from the walk
    input wire logic [31:0] l1_desc_i,
    input wire logic [31:0] l2_desc_i,
    // External aborts from the system bus
    input wire logic ext_abort_i,
    input wire logic walk_abort_i,
    input wire logic walk_abort_level2_i,
    // Results
    output logic bus_req_o,
    output logic data_abort_o,
    output logic prefetch_abort_o
);
    import mmu_fault_pkg::*;

    logic [31:0] main_control_reg_q;
    logic [31:0] domain_table_reg_q;
    logic [7:0] data_status_q;
    logic [7:0] instr_status_q;
    logic [31:0] fault_address_reg_q;
    logic [31:0] rdata_q;
    logic bus_req_q;
    logic data_abort_q;
    logic prefetch_abort_q;
    xfer_state_t xfer_q;
    logic fault_seen_q;
    logic ext_pending_q;
    logic ext_early_q;
    logic [21:0] region_q;
    logic [31:0] last_before_q;

    logic mmu_en;
    logic align_en;
    logic [1:0] l1_type;
    logic [1:0] l2_type;
    logic is_section;
    logic [3:0] l1_domain;
    logic [1:0] dom_code;
    logic [1:0] access_permission_bits;
    logic perm_ok;
    logic align_fault;
    logic walk_fault;
    logic trans_fault;
    logic dom_fault;
    logic perm_fault;
    logic ext_ok;
    logic ext_fault;
    logic check_fault;
    logic any_fault;
    logic [3:0] code_d;
    logic [3:0] domain_d;
    logic prior_fault;
    logic in_first_region;
    logic [31:0] last_before_d;
    logic ext_early_d;

    assign mmu_en = main_control_reg_q[`CTRL_MMU_EN_BIT];
    assign align_en = main_control_reg_q[`CTRL_ALIGN_EN_BIT];
    assign l1_type = l1_desc_i[`DESC_TYPE_LSB +: 2];
    assign l2_type = l2_desc_i[`DESC_TYPE_LSB +: 2];
    assign is_section = (l1_type == DESC_TYPE_10);
    assign l1_domain = l1_desc_i[`L1_DOMAIN_LSB +: 4];

    assign dom_code = domain_table_reg_q[{l1_domain, 1'b0} +: 2];

    // Pick the permission field: section, subpage quarter, or tiny page
    always_comb begin
        access_permission_bits = 2'b00;
        if (is_section) begin
            access_permission_bits = l1_desc_i[`SECTION_AP_LSB +: 2];
        end else begin
            case (l2_type)
                // Large page quarters are 16 KB each
                DESC_TYPE_01: access_permission_bits =
                    l2_desc_i[(`L2_AP_LSB + {modified_virtual_address_i[15:14], 1'b0}) +: 2];
                DESC_TYPE_10: access_permission_bits =
                    l2_desc_i[(`L2_AP_LSB + {modified_virtual_address_i[11:10], 1'b0}) +: 2];
                DESC_TYPE_11: access_permission_bits = l2_desc_i[`L2_AP_LSB +: 2];
                default: access_permission_bits = 2'b00;
            endcase
        end
    end

    // Decode permission bits against privilege, direction and protection bits
    always_comb begin
        perm_ok = 1'b0;
        case (access_permission_bits)
            2'b00: perm_ok = (main_control_reg_q[`CTRL_SYS_PROT_BIT] ^ main_control_reg_q[`CTRL_ROM_PROT_BIT])
                             && !acc_write_i;
            2'b01: perm_ok = acc_priv_i;
            2'b10: perm_ok = acc_priv_i || !acc_write_i;
            2'b11: perm_ok = 1'b1;
            default: perm_ok = 1'b0;
        endcase
    end

    // only the alignment enable and the data-access flag gate it
    assign align_fault = align_en && acc_data_i &&
        (((acc_size_i == SIZE_WORD) && (modified_virtual_address_i[1:0] != 2'b00)) ||
         ((acc_size_i == SIZE_HALF) && modified_virtual_address_i[0]));

    assign walk_fault = mmu_en && walk_abort_i;
    assign trans_fault = mmu_en && ((l1_type == DESC_INVALID) || (!is_section && (l2_type == DESC_INVALID)));
    assign dom_fault = mmu_en && ((dom_code == 2'b00) || (dom_code == 2'b10));
    assign perm_fault = mmu_en && (dom_code == 2'b01) && !perm_ok;

    // only bus-synchronous access kinds take an external abort
    assign ext_ok = (acc_noncached_i && !acc_write_i) || (acc_nonbuffered_i && acc_write_i) || swap_lock_sequence_i;
    assign ext_fault = ext_abort_i && ext_ok;
    assign check_fault = align_fault || walk_fault || trans_fault || dom_fault || perm_fault;
    assign any_fault = check_fault || ext_fault;

    // Priority encoder; lower sources are simply not looked at once a higher one fires
    always_comb begin
        code_d = `FS_EXT_SECTION;
        domain_d = `DOMAIN_INVALID;
        if (align_fault) begin
            code_d = `FS_ALIGN_BASE | {2'b00, modified_virtual_address_i[1], 1'b0};
            domain_d = `DOMAIN_INVALID;
        end else if (walk_fault) begin
            code_d = walk_abort_level2_i ? `FS_WALK_L2 : `FS_WALK_L1;
            domain_d = walk_abort_level2_i ? l1_domain : `DOMAIN_INVALID;
        end else if (trans_fault) begin
            code_d = (l1_type == DESC_INVALID) ? `FS_TRANS_SECTION : `FS_TRANS_PAGE;
            domain_d = (l1_type == DESC_INVALID) ? `DOMAIN_INVALID : l1_domain;
        end else if (dom_fault) begin
            code_d = is_section ? `FS_DOMAIN_SECTION : `FS_DOMAIN_PAGE;
            domain_d = l1_domain;
        end else if (perm_fault) begin
            code_d = is_section ? `FS_PERM_SECTION : `FS_PERM_PAGE;
            domain_d = l1_domain;
        end else begin
            // External aborts outside translation fall back to the section code
            code_d = (mmu_en && !is_section) ? `FS_EXT_PAGE : `FS_EXT_SECTION;
            domain_d = mmu_en ? l1_domain : `DOMAIN_INVALID;
        end
    end

    // Tracking of the first 1 KB region of a multi-word transfer
    assign prior_fault = !acc_first_i && fault_seen_q;
    assign in_first_region = acc_first_i || (modified_virtual_address_i[31:`REGION_LSB] == region_q);
    assign last_before_d = in_first_region ? modified_virtual_address_i : last_before_q;
    assign ext_early_d = (acc_first_i ? 1'b0 : ext_early_q) ||
                         (ext_fault && !check_fault && in_first_region && !(prior_fault && ext_pending_q));

    // suppress the bus transfer of a violating access
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bus_req_q <= 1'b0;
        end else begin
            bus_req_q <= acc_valid_i && !check_fault;
        end
    end

    // abort the access to the core
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_abort_q <= 1'b0;
            prefetch_abort_q <= 1'b0;
        end else begin
            data_abort_q <= acc_valid_i && acc_data_i && any_fault;
            prefetch_abort_q <= acc_valid_i && !acc_data_i && any_fault;
        end
    end

    // Transfer state; a single-word access has both first and last set
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            xfer_q <= XFER_IDLE;
            fault_seen_q <= 1'b0;
            ext_pending_q <= 1'b0;
            ext_early_q <= 1'b0;
            region_q <= 22'h000000;
            last_before_q <= 32'h0000_0000;
        end else if (acc_valid_i) begin
            case (xfer_q)
                XFER_IDLE, XFER_BUSY: begin
                    xfer_q <= acc_last_i ? XFER_IDLE : XFER_BUSY;
                    fault_seen_q <= prior_fault || any_fault;
                    ext_pending_q <= (!acc_first_i && ext_pending_q) || (ext_fault && !check_fault && !prior_fault);
                    ext_early_q <= ext_early_d;
                    last_before_q <= last_before_d;
                    if (acc_first_i) begin
                        region_q <= modified_virtual_address_i[31:`REGION_LSB];
                    end
                end
                default: begin
                    xfer_q <= XFER_IDLE;
                end
            endcase
        end
    end

    // data status capture; a hardware capture wins over a software write
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_status_q <= `FAULT_STATUS_RESET;
        end else if (acc_valid_i && acc_data_i && any_fault && !prior_fault) begin
            data_status_q <= {domain_d, code_d};
        end else if (reg_write_i && (reg_addr_i == `REG_DATA_FAULT_STATUS)) begin
            data_status_q <= reg_wdata_i[7:0];
        end
    end

    // prefetch abort writes instruction status only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            instr_status_q <= `FAULT_STATUS_RESET;
        end else if (acc_valid_i && !acc_data_i && any_fault && !prior_fault) begin
            instr_status_q <= {domain_d, code_d};
        end else if (reg_write_i && (reg_addr_i == `REG_INSTR_FAULT_STATUS)) begin
            instr_status_q <= reg_wdata_i[7:0];
        end
    end

    // Fault address: first aborted word, or end-of-transfer choice for external aborts
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fault_address_reg_q <= `FAULT_ADDRESS_RESET;
        end else if (acc_valid_i && acc_data_i && check_fault && !prior_fault) begin
            fault_address_reg_q <= modified_virtual_address_i;
        end else if (acc_valid_i && acc_data_i && acc_last_i &&
                     ((!acc_first_i && ext_pending_q) || (ext_fault && !check_fault && !prior_fault))) begin
            fault_address_reg_q <= ext_early_d ? last_before_d : modified_virtual_address_i;
        end else if (reg_write_i && (reg_addr_i == `REG_FAULT_ADDRESS)) begin
            fault_address_reg_q <= reg_wdata_i;
        end
    end

    // Control and domain table, software owned
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            main_control_reg_q <= `CTRL_RESET;
            domain_table_reg_q <= `DOMAIN_TABLE_RESET;
        end else if (reg_write_i) begin
            if (reg_addr_i == `REG_MAIN_CONTROL) begin
                main_control_reg_q <= reg_wdata_i;
            end
            if (reg_addr_i == `REG_DOMAIN_TABLE) begin
                domain_table_reg_q <= reg_wdata_i;
            end
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_read_i) begin
            case (reg_addr_i)
                `REG_MAIN_CONTROL: rdata_q <= main_control_reg_q;
                `REG_DOMAIN_TABLE: rdata_q <= domain_table_reg_q;
                `REG_DATA_FAULT_STATUS: rdata_q <= {24'h000000, data_status_q};
                `REG_INSTR_FAULT_STATUS: rdata_q <= {24'h000000, instr_status_q};
                `REG_FAULT_ADDRESS: rdata_q <= fault_address_reg_q;
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign bus_req_o = bus_req_q;
    assign data_abort_o = data_abort_q;
    assign prefetch_abort_o = prefetch_abort_q;
endmodule

// ### test/mmu_fault_check_assertions.sv
`timescale 1ns/1ns
`include "mmu_fault_map.svh"
module mmu_fault_check_assertions (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic acc_valid_i,
    input wire logic acc_data_i,
    input wire logic acc_write_i,
    input wire mmu_fault_pkg::access_size_t acc_size_i,
    input wire logic [31:0] modified_virtual_address_i,
    input wire logic acc_noncached_i,
    input wire logic acc_nonbuffered_i,
    input wire logic swap_lock_sequence_i,
    input wire logic ext_abort_i,
    input wire logic bus_req_o,
    input wire logic data_abort_o,
    input wire logic prefetch_abort_o
);
    import mmu_fault_pkg::*;
    logic [1:0] mode_q;
    logic ext_ok;
    logic misaligned;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // Mode bits: 0 translation, 1 alignment
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_q <= 2'h0;
        end else if (reg_write_i && reg_addr_i == `REG_MAIN_CONTROL) begin
            mode_q <= reg_wdata_i[1:0];
        end
    end
    // Bus-synchronous kinds and misaligned data
    assign ext_ok = (acc_noncached_i && !acc_write_i) || (acc_nonbuffered_i && acc_write_i) || swap_lock_sequence_i;
    assign misaligned = acc_data_i && ((acc_size_i == SIZE_WORD && modified_virtual_address_i[1:0] != 2'h0)
        || (acc_size_i == SIZE_HALF && modified_virtual_address_i[0]));

    AST_ALIGN_ABORT: assert property (acc_valid_i && mode_q[1] && misaligned |=>
        data_abort_o && !bus_req_o && !prefetch_abort_o) else $error("misaligned access not aborted");
    AST_OFF_NO_FAULT: assert property (acc_valid_i && mode_q == 2'h0 && !ext_abort_i |=>
        bus_req_o && !data_abort_o && !prefetch_abort_o) else $error("fault raised with checks off");
    AST_ALIGNED_PASSES: assert property (acc_valid_i && mode_q == 2'h2 && !misaligned && !ext_abort_i |=>
        bus_req_o && !data_abort_o) else $error("aligned, byte or fetch access aborted");
    AST_EXT_IGNORED: assert property (acc_valid_i && mode_q == 2'h0 && ext_abort_i && !ext_ok |=>
        bus_req_o && !data_abort_o && !prefetch_abort_o) else $error("ineligible external abort taken");
    AST_EXT_TAKEN: assert property (acc_valid_i && acc_data_i && mode_q == 2'h0 && ext_abort_i && ext_ok |=>
        data_abort_o) else $error("eligible external abort lost");
    AST_FETCH_NOT_DATA: assert property (acc_valid_i && !acc_data_i |=> !data_abort_o)
        else $error("fetch gave a data abort");
    AST_QUIET_IDLE: assert property (!acc_valid_i |=> !bus_req_o && !data_abort_o && !prefetch_abort_o)
        else $error("output without an access");
    AST_STATUS_UPPER: assert property (reg_read_i && reg_addr_i inside {5'h08, 5'h0C} |=>
        reg_rdata_o[31:8] == 24'h0) else $error("status upper bits not zero");
    AST_UNMAPPED_ZERO: assert property (reg_read_i && reg_addr_i > 5'h10 |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    // Main scenarios reached
    cover property (data_abort_o && !bus_req_o);
    cover property (prefetch_abort_o);
    cover property (data_abort_o && bus_req_o);
endmodule

bind mmu_fault_check mmu_fault_check_assertions mmu_fault_check_assertions_inst (.clk_i, .reset_i, .reg_addr_i,
    .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .acc_valid_i, .acc_data_i, .acc_write_i, .acc_size_i,
    .modified_virtual_address_i, .acc_noncached_i, .acc_nonbuffered_i, .swap_lock_sequence_i, .ext_abort_i,
    .bus_req_o, .data_abort_o, .prefetch_abort_o);

// ### test/core_model.sv
`timescale 1ns/1ns
module core_model (
    input wire logic clk_i,
    input wire logic bus_req_i,
    input wire logic data_abort_i,
    input wire logic prefetch_abort_i,
    output logic valid_o,
    output logic [6:0] kind_o,
    output mmu_fault_pkg::access_size_t size_o,
    output logic [31:0] addr_o,
    output logic first_o,
    output logic last_o
);
    import mmu_fault_pkg::*;
    logic [2:0] last_q = 3'h0;
    int n_abort = 0;
    // Quiet bus at time zero
    initial begin
        valid_o = 1'b0;
        kind_o = 7'h00;
        size_o = SIZE_WORD;
        addr_o = 32'h0;
        first_o = 1'b0;
        last_o = 1'b0;
    end
    // Latest answer and abort count
    always @(posedge clk_i) begin
        if (bus_req_i || data_abort_i || prefetch_abort_i) begin
            last_q <= {bus_req_i, data_abort_i, prefetch_abort_i};
        end
        if (data_abort_i || prefetch_abort_i) begin
            n_abort <= n_abort + 1;
        end
    end
    // One word per clock; kind is {data, write, priv, noncached, nonbuffered, swap, external abort}
    task automatic word(input logic [6:0] k, input logic [1:0] s, input logic [31:0] a, input logic f, input logic l);
        @(posedge clk_i);
        valid_o <= 1'b1;
        kind_o <= k;
        size_o <= access_size_t'(s);
        addr_o <= a;
        first_o <= f;
        last_o <= l;
    endtask
    // Release, leaving no stale address or abort
    task automatic done();
        @(posedge clk_i);
        valid_o <= 1'b0;
        addr_o <= ~addr_o;
        kind_o[0] <= ~kind_o[0];
        @(posedge clk_i);
        #1;
    endtask
endmodule

// ### test/mmu_fault_check_bench.sv
`timescale 1ns/1ns
`include "mmu_fault_map.svh"
module mmu_fault_check_bench;
    import mmu_fault_pkg::*;
    typedef struct packed {
        logic [9:0] ctl; logic [3:0] dac; logic [11:0] l1; logic [11:0] l2; logic [6:0] kind;
        logic [1:0] size; logic [11:0] addr; logic [1:0] ab; logic [2:0] exp; logic [7:0] st;
    } row_t;
    logic clk_i, reset_i, reg_write_i, reg_read_i, walk_abort_i, walk_abort_level2_i;
    logic acc_valid_i, acc_data_i, acc_write_i, acc_priv_i, acc_first_i, acc_last_i, acc_noncached_i;
    logic acc_nonbuffered_i, swap_lock_sequence_i, ext_abort_i, bus_req_o, data_abort_o, prefetch_abort_o;
    logic [4:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, l1_desc_i, l2_desc_i, modified_virtual_address_i, v;
    access_size_t acc_size_i;
    row_t r;
    int n_errors = 0;
    int tests_run = 0;
    // Rows: mode, domains, descriptors, access; outputs {bus, data, fetch}, status
    row_t rows [29] = '{
        '{10'h002,4'h4,12'h422,12'h0,7'h50,2'h2,12'h101,2'h0,3'h2,8'h01},
        '{10'h000,4'h4,12'h422,12'h0,7'h50,2'h2,12'h101,2'h0,3'h4,8'h00},
        '{10'h002,4'h4,12'h422,12'h0,7'h50,2'h0,12'h103,2'h0,3'h4,8'h00},
        '{10'h002,4'h4,12'h422,12'h0,7'h50,2'h1,12'h101,2'h0,3'h2,8'h01},
        '{10'h002,4'h4,12'h422,12'h0,7'h10,2'h2,12'h102,2'h0,3'h4,8'h00},
        '{10'h003,4'h4,12'h000,12'h0,7'h50,2'h2,12'h102,2'h0,3'h2,8'h03},
        '{10'h003,4'h4,12'h000,12'h0,7'h50,2'h2,12'h100,2'h0,3'h2,8'h05},
        '{10'h000,4'h4,12'h000,12'h0,7'h50,2'h2,12'h100,2'h0,3'h4,8'h00},
        '{10'h001,4'h4,12'h021,12'h0,7'h50,2'h2,12'h100,2'h0,3'h2,8'h17},
        '{10'h001,4'h0,12'h422,12'h0,7'h40,2'h2,12'h100,2'h0,3'h2,8'h19},
        '{10'h001,4'h8,12'h422,12'h0,7'h50,2'h2,12'h100,2'h0,3'h2,8'h19},
        '{10'h001,4'h4,12'h422,12'h0,7'h70,2'h2,12'h100,2'h0,3'h4,8'h00},
        '{10'h001,4'h4,12'h822,12'h0,7'h60,2'h2,12'h100,2'h0,3'h2,8'h1D},
        '{10'h001,4'h4,12'hC22,12'h0,7'h60,2'h2,12'h100,2'h0,3'h4,8'h00},
        '{10'h001,4'hC,12'h422,12'h0,7'h60,2'h2,12'h100,2'h0,3'h4,8'h00},
        '{10'h001,4'h4,12'h022,12'h0,7'h50,2'h2,12'h100,2'h0,3'h2,8'h1D},
        '{10'h101,4'h4,12'h022,12'h0,7'h70,2'h2,12'h100,2'h0,3'h2,8'h1D},
        '{10'h001,4'h4,12'h021,12'hFD2,7'h60,2'h2,12'h100,2'h0,3'h2,8'h1F},
        '{10'h001,4'h4,12'h021,12'hFD2,7'h60,2'h2,12'hC00,2'h0,3'h4,8'h00},
        '{10'h001,4'hC,12'hC22,12'h0,7'h59,2'h2,12'h100,2'h0,3'h6,8'h18},
        '{10'h000,4'hC,12'hC22,12'h0,7'h51,2'h2,12'h100,2'h0,3'h4,8'h00},
        '{10'h001,4'hC,12'hC22,12'h0,7'h75,2'h2,12'h100,2'h0,3'h6,8'h18},
        '{10'h001,4'hC,12'h021,12'hFF2,7'h53,2'h2,12'h100,2'h0,3'h6,8'h1A},
        '{10'h000,4'h4,12'h422,12'h0,7'h59,2'h2,12'h100,2'h0,3'h6,8'h08},
        '{10'h001,4'h4,12'h000,12'h0,7'h50,2'h2,12'h100,2'h2,3'h2,8'h0C},
        '{10'h001,4'h4,12'h021,12'h0,7'h50,2'h2,12'h100,2'h3,3'h2,8'h1E},
        '{10'h001,4'h4,12'h021,12'hFD1,7'h60,2'h2,12'hC00,2'h0,3'h2,8'h1F},
        '{10'h001,4'h4,12'h021,12'h013,7'h60,2'h2,12'h100,2'h0,3'h2,8'h1F},
        '{10'h001,4'h4,12'h000,12'h0,7'h10,2'h2,12'h100,2'h0,3'h1,8'h05}
    };

    mmu_fault_check mmu_fault_check_inst (.*);
    core_model core_model_inst (.clk_i(clk_i), .bus_req_i(bus_req_o), .data_abort_i(data_abort_o),
        .prefetch_abort_i(prefetch_abort_o), .valid_o(acc_valid_i), .size_o(acc_size_i),
        .kind_o({acc_data_i, acc_write_i, acc_priv_i, acc_noncached_i, acc_nonbuffered_i, swap_lock_sequence_i,
        ext_abort_i}), .addr_o(modified_virtual_address_i), .first_o(acc_first_i), .last_o(acc_last_i));

    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Register write and read with a gap cycle after each strobe
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
        reg_wdata_i <= ~d;
    endtask
    task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_out(input string what, input logic [2:0] exp, input logic [2:0] got);
        check_reg(what, {29'h0, exp}, {29'h0, got});
    endtask
    task automatic expect_reg(input string what, input logic [4:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1 v = reg_rdata_o;
        check_reg(what, exp, v);
    endtask
    // Mode, domains, cleared status, preloaded fault address
    task automatic setup(input logic [9:0] c, input logic [3:0] d);
        wr(`REG_MAIN_CONTROL, {22'h0, c});
        wr(`REG_DOMAIN_TABLE, {28'h0, d});
        wr(`REG_DATA_FAULT_STATUS, 32'h0);
        wr(`REG_INSTR_FAULT_STATUS, 32'h0);
        wr(`REG_FAULT_ADDRESS, 32'hFFFF_FFFF);
        core_model_inst.n_abort = 0;
    endtask
    task automatic results();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog; the run needs about six hundred cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("ERROR watchdog expected done seen hang");
        results();
    end
    initial begin
        reset_i = 1'b1;
        {reg_write_i, reg_read_i, reg_addr_i, reg_wdata_i} = 39'h0;
        {l1_desc_i, l2_desc_i, walk_abort_i, walk_abort_level2_i} = 66'h0;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        // Reset values; unmapped place ignores writes
        for (int a = 0; a <= 20; a += 4) expect_reg("reset value", 5'(a), 32'h0);
        wr(5'h14, 32'hFFFF_FFFF);
        expect_reg("unmapped", 5'h14, 32'h0);
        wr(`REG_DOMAIN_TABLE, 32'hA5A5_5A5A);
        expect_reg("domain table", `REG_DOMAIN_TABLE, 32'hA5A5_5A5A);
        wr(`REG_INSTR_FAULT_STATUS, 32'h0000_00C7);
        expect_reg("prefetch op status", `REG_INSTR_FAULT_STATUS, 32'h0000_00C7);
        foreach (rows[i]) begin
            r = rows[i];
            setup(r.ctl, r.dac);
            l1_desc_i <= {20'h0, r.l1};
            l2_desc_i <= {20'h0, r.l2};
            {walk_abort_i, walk_abort_level2_i} <= r.ab;
            core_model_inst.word(r.kind, r.size, {20'h0, r.addr}, 1'b1, 1'b1);
            core_model_inst.done();
            check_out("outputs", r.exp, core_model_inst.last_q);
            expect_reg("status", r.kind[6] ? 5'h08 : 5'h0C, {24'h0, r.st});
            expect_reg("fault address", 5'h10, r.exp[1] ? {20'h0, r.addr} : 32'hFFFF_FFFF);
        end
        // Multi-word, checked faults on words two and three
        setup(10'h003, 4'h4);
        l1_desc_i <= 32'h0000_0C22;
        {walk_abort_i, walk_abort_level2_i} <= 2'h0;
        core_model_inst.word(7'h50, 2'h2, 32'h0000_0100, 1'b1, 1'b0);
        core_model_inst.word(7'h50, 2'h2, 32'h0000_0105, 1'b0, 1'b0);
        core_model_inst.word(7'h50, 2'h2, 32'h0000_0109, 1'b0, 1'b1);
        core_model_inst.done();
        check_reg("abort count", 32'h0000_0002, 32'(core_model_inst.n_abort));
        expect_reg("first fault status", `REG_DATA_FAULT_STATUS, 32'h0000_0001);
        expect_reg("first fault address", `REG_FAULT_ADDRESS, 32'h0000_0105);
        // External aborts around the 1 KB boundary, early then late
        for (int t = 0; t < 2; t++) begin
            setup(10'h001, 4'hC);
            for (int w = 0; w < 4; w++) begin
                core_model_inst.word(7'h58 | 7'(w == 2 || (w == 1 && t == 0)), 2'h2, 32'h0000_03F8 + 32'(4 * w),
                    1'(w == 0), 1'(w == 3));
            end
            core_model_inst.done();
            expect_reg("external status", `REG_DATA_FAULT_STATUS, 32'h0000_0018);
            expect_reg("boundary address", 5'h10, t == 0 ? 32'h0000_03FC : 32'h0000_0404);
        end
        // Mid-run reset clears registers
        wr(`REG_DOMAIN_TABLE, 32'h0000_0055);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        expect_reg("reset domains", `REG_DOMAIN_TABLE, 32'h0);
        expect_reg("reset status", `REG_DATA_FAULT_STATUS, 32'h0);
        results();
    end
endmodule
